// *** bench/sfm_spi_master.sv ***
`timescale 1ns/10ps
module sfm_spi_master (
	// Serial pins toward the device
	output logic o_sck,
	output logic o_cs_n,
	output logic o_mosi,
	output logic o_wp_n,
	output logic o_hold_n,
	// Line one as seen on the wire
	input wire logic i_miso
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
		o_wp_n = 1'b1;
		o_hold_n = 1'b1;
	end
	task automatic set_wp(input logic v);
		o_wp_n = v;
	endtask
	task automatic set_hold(input logic v);
		o_hold_n = v;
	endtask
	// Clock stands still outside frames, at the idle level of the mode
	task automatic frame(input logic m3, input logic [7:0] c, input logic [23:0] d,
		input int nb, output logic [7:0] rd);
		logic [31:0] sh;
		sh = {c, d << (8 * (3 - nb))};
		// Keep pin changes off the device clock edges
		#2;
		o_sck = m3;
		#40;
		o_cs_n = 1'b0;
		#40;
		for (int i = 0; i < 8 * (nb + 1); i++) begin
			o_sck = 1'b0;
			o_mosi = sh[31 - i];
			#40;
			o_sck = 1'b1;
			rd = {rd[6:0], i_miso};
			#40;
		end
		o_sck = m3;
		#40;
		o_cs_n = 1'b1;
		#200;
	endtask
endmodule // sfm_spi_master

// *** bench/tb.sv ***
`timescale 1ns/10ps
`include "sfm_defs.svh"
module tb;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} sfm_row_type;
	typedef struct packed {
		logic [2:0] dn; logic [7:0] c; logic [23:0] ad; logic [23:0] base; logic [2:0] ev;
	} sfm_ers_type;
	logic i_clk, i_reset_n, cyc, stb, we, last1;
	logic [7:0] adr, rd;
	logic [31:0] wdat, q;
	wire logic [31:0] rdat;
	wire logic ack, irq, sck, cs_n, mosi, wp_n, hold_n;
	wire logic [3:0] io_out, oe_n;
	int errors, n_tests;
	// Released line one shows the inverse of its last driven level
	wire logic [3:0] m_io = {hold_n, wp_n, ~last1, mosi};
	wire logic [3:0] io_in = (oe_n & m_io) | (~oe_n & io_out);
	sfm_row_type rows [10] = '{
		'{1'b0, `SFM_REG_STATUS, 32'h0, 32'h0}, '{1'b0, `SFM_REG_CONFIG, 32'h0, 32'h4},
		'{1'b1, `SFM_REG_CONFIG, 32'h2, 32'h0}, '{1'b0, `SFM_REG_CONFIG, 32'h0, 32'h2},
		'{1'b1, `SFM_REG_CONFIG, 32'h4, 32'h0}, '{1'b1, `SFM_REG_STATUS, 32'hFF, 32'h0},
		'{1'b0, `SFM_REG_STATUS, 32'h0, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0},
		'{1'b1, `SFM_REG_IMASK, 32'h7, 32'h0}, '{1'b0, `SFM_REG_IMASK, 32'h0, 32'h7}};
	sfm_ers_type ers [7] = '{
		'{3'h4, `SFM_CMD_BE64, 24'h012345, 24'h010000, 3'h2},
		'{3'h4, `SFM_CMD_BE32, 24'h01ABCD, 24'h018000, 3'h2},
		'{3'h4, `SFM_CMD_SE, 24'h07FFFF, 24'h07F000, 3'h2},
		'{3'h0, `SFM_CMD_SE, 24'h0FF123, 24'h007000, 3'h2},
		'{3'h0, `SFM_CMD_BE64, 24'h003000, 24'h007000, 3'h4},
		'{3'h2, `SFM_CMD_BE64, 24'h01FFFF, 24'h010000, 3'h2},
		'{3'h1, `SFM_CMD_BE32, 24'h00FFFF, 24'h008000, 3'h2}};
	sfm_top sfm_top_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .o_irq(irq), .i_sck(sck), .i_cs_n(cs_n), .i_io_in(io_in),
		.o_io_out(io_out), .o_io_oe_n(oe_n));
	sfm_spi_master sfm_spi_master_inst (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi),
		.o_wp_n(wp_n), .o_hold_n(hold_n), .i_miso(io_in[1]));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (!oe_n[1]) last1 <= io_out[1];
	task automatic stop_test;
		if (errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Polls status until the busy flag drops, bounded
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			wb(1'b0, `SFM_REG_STATUS, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 400);
		if (n >= 400) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic spi(input logic m3, input logic [7:0] c, input logic [23:0] d, input int nb);
		sfm_spi_master_inst.frame(m3, c, d, nb, rd);
	endtask
	task automatic latch_on;
		spi(1'b0, `SFM_CMD_LATCH_SET, 24'h0, 0);
	endtask
	initial begin
		{cyc, stb, we, last1, adr, wdat, i_reset_n, errors, n_tests} = '0;
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		chk({27'h0, irq, oe_n}, 32'hF);
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].e);
		end
		spi(1'b0, `SFM_CMD_RDSR, 24'h0, 1);
		chk({24'h0, rd}, 32'h0);
		spi(1'b1, `SFM_CMD_LATCH_SET, 24'h0, 0);
		spi(1'b1, `SFM_CMD_RDSR, 24'h0, 1);
		chk({24'h0, rd}, 32'h2);
		spi(1'b1, `SFM_CMD_LATCH_CLR, 24'h0, 0);
		spi(1'b0, `SFM_CMD_RDSR, 24'h0, 1);
		chk({24'h0, rd}, 32'h0);
		latch_on();
		spi(1'b0, `SFM_CMD_STAT_WR, 24'h3D, 1);
		rdchk(`SFM_REG_STATUS, 32'h3);
		wait_idle();
		chk(q, 32'h3C);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `SFM_REG_IMASK, 32'h0);
		rdchk(`SFM_REG_ISTAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, `SFM_REG_IMASK, 32'h7);
		wb(1'b1, `SFM_REG_ISTAT, 32'h1);
		rdchk(`SFM_REG_ISTAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		latch_on();
		spi(1'b0, `SFM_CMD_SE, 24'h001000, 3);
		rdchk(`SFM_REG_ISTAT, 32'h4);
		latch_on();
		spi(1'b0, `SFM_CMD_STAT_WR, 24'h80, 1);
		wait_idle();
		chk(q, 32'h80);
		wb(1'b1, `SFM_REG_ISTAT, 32'h7);
		sfm_spi_master_inst.set_wp(1'b0);
		latch_on();
		spi(1'b0, `SFM_CMD_STAT_WR, 24'h0, 1);
		wait_idle();
		chk(q, 32'h82);
		rdchk(`SFM_REG_ISTAT, 32'h4);
		sfm_spi_master_inst.set_wp(1'b1);
		spi(1'b0, `SFM_CMD_STAT_WR, 24'h0, 1);
		wait_idle();
		chk(q, 32'h0);
		wb(1'b1, `SFM_REG_ISTAT, 32'h7);
		foreach (ers[i]) begin
			wb(1'b1, `SFM_REG_CONFIG, {29'h0, ers[i].dn});
			latch_on();
			spi(1'b0, ers[i].c, ers[i].ad, 3);
			wait_idle();
			rdchk(`SFM_REG_EADDR, {8'h0, ers[i].base});
			rdchk(`SFM_REG_ISTAT, {29'h0, ers[i].ev});
			wb(1'b1, `SFM_REG_ISTAT, 32'h7);
		end
		// Pause held through a whole frame: no edge may count
		sfm_spi_master_inst.set_hold(1'b0);
		latch_on();
		sfm_spi_master_inst.set_hold(1'b1);
		rdchk(`SFM_REG_STATUS, 32'h0);
		latch_on();
		spi(1'b0, `SFM_CMD_STAT_WR, 24'h44, 1);
		wait_idle();
		chk(q, 32'h44);
		latch_on();
		spi(1'b0, `SFM_CMD_QRDSR, 24'h0, 1);
		chk({24'h0, rd}, 32'h55);
		// Reset in mid-run drops quad mode and the latch
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		chk({27'h0, irq, oe_n}, 32'hF);
		rdchk(`SFM_REG_STATUS, 32'h0);
		rdchk(`SFM_REG_CONFIG, 32'h4);
		stop_test();
	end
endmodule // tb

// *** hw/sfm_defs.svh ***
`ifndef SFM_DEFS_SVH
`define SFM_DEFS_SVH
`define SFM_CLK_MHZ 100
`define SFM_WRITE_TIME_NS 5000
`define SFM_BUSY_CYC ((`SFM_WRITE_TIME_NS * `SFM_CLK_MHZ + 999) / 1000)
`define SFM_CMD_STAT_WR 8'h01
`define SFM_CMD_LATCH_CLR 8'h04
`define SFM_CMD_RDSR 8'h05
`define SFM_CMD_LATCH_SET 8'h06
`define SFM_CMD_QRDSR 8'hAF
`define SFM_CMD_SE 8'h20
`define SFM_CMD_BE32 8'h52
`define SFM_CMD_BE64 8'hD8
`define SFM_REG_STATUS 8'h00
`define SFM_REG_CONFIG 8'h04
`define SFM_REG_ISTAT 8'h08
`define SFM_REG_IMASK 8'h0C
`define SFM_REG_EADDR 8'h10
`define SFM_SIZE_MIN 24'h008000
`define SFM_SECT_SPAN 24'h000FFF
`define SFM_BLK32_SPAN 24'h007FFF
`define SFM_BLK64_SPAN 24'h00FFFF
`define SFM_DENS_RESET 3'h4
`define SFM_DENS_BLK64_MIN 3'h2
`define SFM_STAT_RESET 8'h00
`define SFM_WR_BITS 5'h08
`define SFM_ADDR_BITS 5'h18
`define SFM_EV_WDONE 0
`define SFM_EV_EDONE 1
`define SFM_EV_REFUSE 2
`endif

// *** hw/sfm_pkg.sv ***
package sfm_pkg;
	typedef struct packed {
		logic lock;
		logic quad_io_enable;
		logic [3:0] bp;
		logic write_enable_latch;
		logic busy;
	} sfm_status_type;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_CMD = 5'h02,
		S_DATA = 5'h04,
		S_OUT = 5'h08,
		S_SKIP = 5'h10
	} sfm_phase_type;
	typedef struct packed {
		logic [3:0] io;
		logic sck;
		logic cs_n;
	} sfm_pins_type;
	typedef struct packed {
		sfm_pins_type s1;
		sfm_pins_type s2;
		logic sck_d;
		sfm_phase_type phase;
		logic [7:0] cmd;
		logic [4:0] bcnt;
		logic [23:0] shin;
		logic [7:0] osh;
		logic [2:0] ocnt;
		logic quad;
		sfm_status_type stat;
		logic [7:0] wr_val;
		logic wr_pend;
		logic [15:0] tmr;
		logic [23:0] ers_addr;
		logic [2:0] dens;
		logic [2:0] ists;
		logic [2:0] imask;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic irq;
		logic [3:0] io_out;
		logic [3:0] io_oe_n;
	} sfm_state_type;
endpackage

// *** hw/sfm_top.sv ***
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "sfm_defs.svh"
module sfm_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Interrupt
	output logic o_irq,
	// Serial pins
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io_in,
	output logic [3:0] o_io_out,
	output logic [3:0] o_io_oe_n
);
	sfm_pkg::sfm_state_type r, n;
	logic rise, fall, hold, locked, bus_go;
	logic [23:0] addr_m;
	logic [2:0] clr;

	function automatic logic [23:0] dens_top(input logic [2:0] d);
		return (`SFM_SIZE_MIN << d) - 24'h000001;
	endfunction

	function automatic logic [23:0] blk_span(input logic [7:0] c);
		if (c == `SFM_CMD_BE64) begin
			return `SFM_BLK64_SPAN;
		end else if (c == `SFM_CMD_BE32) begin
			return `SFM_BLK32_SPAN;
		end
		return `SFM_SECT_SPAN;
	endfunction

	// Either idle level works: only edges matter
	assign rise = r.s2.sck & ~r.sck_d;
	assign fall = ~r.s2.sck & r.sck_d;
	// Pause and protect only count while quad mode is off
	assign hold = ~r.stat.quad_io_enable & ~r.s2.io[3];
	assign locked = r.stat.lock & ~r.stat.quad_io_enable & ~r.s2.io[2];
	assign bus_go = i_wb_cyc & i_wb_stb & ~r.wb_ack;
	assign addr_m = r.shin & dens_top(r.dens);
	assign clr = (bus_go & i_wb_we & i_wb_sel[0] & (i_wb_adr == `SFM_REG_ISTAT)) ?
		i_wb_dat[2:0] : 3'h0;

	always_comb begin
		n = r;
		n.s1 = '{io: i_io_in, sck: i_sck, cs_n: i_cs_n};
		n.s2 = r.s1;
		n.sck_d = r.s2.sck;
		n.ists = r.ists & ~clr;
		// Busy timer; a finished write drops the latch
		if (r.stat.busy) begin
			if (r.tmr == 16'h0000) begin
				n.stat.busy = 1'b0;
				n.stat.write_enable_latch = 1'b0;
				if (r.wr_pend) begin
					n.stat.lock = r.wr_val[7];
					n.stat.quad_io_enable = r.wr_val[6];
					n.stat.bp = r.wr_val[5:2];
					n.wr_pend = 1'b0;
					n.ists[`SFM_EV_WDONE] = 1'b1;
				end else begin
					n.ists[`SFM_EV_EDONE] = 1'b1;
				end
			end else begin
				n.tmr = r.tmr - 16'h0001;
			end
		end
		if (r.s2.cs_n) begin
			// Commands act when select rises
			if (r.phase != sfm_pkg::S_IDLE) begin
				if (r.cmd == `SFM_CMD_LATCH_SET && r.phase == sfm_pkg::S_SKIP) begin
					if (!r.stat.busy) begin
						n.stat.write_enable_latch = 1'b1;
					end
				end else if (r.cmd == `SFM_CMD_LATCH_CLR && r.phase == sfm_pkg::S_SKIP) begin
					if (!r.stat.busy) begin
						n.stat.write_enable_latch = 1'b0;
					end
				end else if (r.cmd == `SFM_CMD_STAT_WR && r.bcnt == `SFM_WR_BITS) begin
					if (r.stat.write_enable_latch && !r.stat.busy) begin
						if (locked) begin
							n.ists[`SFM_EV_REFUSE] = 1'b1;
						end else begin
							n.wr_val = r.shin[7:0];
							n.wr_pend = 1'b1;
							n.stat.busy = 1'b1;
							n.tmr = 16'(`SFM_BUSY_CYC - 1);
						end
					end
				end else if (r.phase == sfm_pkg::S_DATA && r.bcnt == `SFM_ADDR_BITS) begin
					if (r.stat.write_enable_latch && !r.stat.busy) begin
						// No 64 KB blocks on the two small densities
						// Any set protect bit guards the whole array
						if ((r.cmd == `SFM_CMD_BE64 && r.dens < `SFM_DENS_BLK64_MIN) ||
							r.stat.bp != 4'h0) begin
							n.ists[`SFM_EV_REFUSE] = 1'b1;
						end else begin
							n.ers_addr = addr_m & ~blk_span(r.cmd);
							n.stat.busy = 1'b1;
							n.tmr = 16'(`SFM_BUSY_CYC - 1);
						end
					end
				end
			end
			n.phase = sfm_pkg::S_IDLE;
			n.bcnt = 5'h00;
			n.io_oe_n = 4'hF;
		end else if (hold) begin
			n.io_oe_n[1] = 1'b1;
		end else begin
			if (r.phase == sfm_pkg::S_IDLE) begin
				n.phase = sfm_pkg::S_CMD;
			end
			if (rise) begin
				// Shift in MSB first
				if (r.phase == sfm_pkg::S_IDLE || r.phase == sfm_pkg::S_CMD) begin
					n.shin = {r.shin[22:0], r.s2.io[0]};
					n.bcnt = r.bcnt + 5'h01;
					if (r.bcnt == 5'h07) begin
						n.cmd = {r.shin[6:0], r.s2.io[0]};
						n.bcnt = 5'h00;
						n.osh = r.stat;
						n.ocnt = 3'h0;
						n.quad = 1'b0;
						n.phase = sfm_pkg::S_SKIP;
						if (n.cmd == `SFM_CMD_RDSR) begin
							n.phase = sfm_pkg::S_OUT;
						end else if (n.cmd == `SFM_CMD_QRDSR && r.stat.quad_io_enable) begin
							n.phase = sfm_pkg::S_OUT;
							n.quad = 1'b1;
						end else if (n.cmd == `SFM_CMD_STAT_WR || n.cmd == `SFM_CMD_SE ||
							n.cmd == `SFM_CMD_BE32 || n.cmd == `SFM_CMD_BE64) begin
							n.phase = sfm_pkg::S_DATA;
						end
					end
				end else if (r.phase == sfm_pkg::S_DATA) begin
					n.shin = {r.shin[22:0], r.s2.io[0]};
					if (r.bcnt != 5'h1F) begin
						n.bcnt = r.bcnt + 5'h01;
					end
				end
			end
			if (fall && r.phase == sfm_pkg::S_OUT) begin
				// Launch on falling edges, status repeats
				if (r.quad) begin
					n.io_out = r.osh[7:4];
					n.io_oe_n = 4'h0;
					n.osh = {r.osh[3:0], 4'h0};
					n.ocnt = r.ocnt + 3'h4;
				end else begin
					n.io_out[1] = r.osh[7];
					n.io_oe_n[1] = 1'b0;
					n.osh = {r.osh[6:0], 1'b0};
					n.ocnt = r.ocnt + 3'h1;
				end
				if (n.ocnt == 3'h0) begin
					n.osh = r.stat;
				end
			end
		end
		// Register bus
		n.wb_ack = bus_go;
		n.wb_dat = 32'h00000000;
		if (bus_go && i_wb_we && i_wb_sel[0]) begin
			if (i_wb_adr == `SFM_REG_CONFIG) begin
				n.dens = i_wb_dat[2:0];
			end else if (i_wb_adr == `SFM_REG_IMASK) begin
				n.imask = i_wb_dat[2:0];
			end
		end else if (bus_go && !i_wb_we) begin
			if (i_wb_adr == `SFM_REG_STATUS) begin
				n.wb_dat = {24'h000000, r.stat};
			end else if (i_wb_adr == `SFM_REG_CONFIG) begin
				n.wb_dat = {29'h00000000, r.dens};
			end else if (i_wb_adr == `SFM_REG_ISTAT) begin
				n.wb_dat = {29'h00000000, r.ists};
			end else if (i_wb_adr == `SFM_REG_IMASK) begin
				n.wb_dat = {29'h00000000, r.imask};
			end else if (i_wb_adr == `SFM_REG_EADDR) begin
				n.wb_dat = {8'h00, r.ers_addr};
			end
		end
		n.irq = |(n.ists & n.imask);
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r <= '0;
			r.phase <= sfm_pkg::S_IDLE;
			r.stat <= `SFM_STAT_RESET;
			r.dens <= `SFM_DENS_RESET;
			r.io_oe_n <= 4'hF;
			r.s1.cs_n <= 1'b1;
			r.s2.cs_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign o_wb_dat = r.wb_dat;
	assign o_wb_ack = r.wb_ack;
	assign o_irq = r.irq;
	assign o_io_out = r.io_out;
	assign o_io_oe_n = r.io_oe_n;

	// Checks
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	localparam int BUSY_MAX = `SFM_BUSY_CYC + 2;

	busy_ends_a: assert property ($rose(r.stat.busy) |-> ##[1:BUSY_MAX] !r.stat.busy)
		else $error("busy never cleared");
	latch_drop_a: assert property ($fell(r.stat.busy) |-> !r.stat.write_enable_latch)
		else $error("write latch kept after write");
	latch_set_a: assert property ($rose(r.stat.write_enable_latch) |->
		r.cmd == `SFM_CMD_LATCH_SET)
		else $error("write latch set by other command");
	lock_ignore_a: assert property ($rose(r.wr_pend) |-> !$past(locked))
		else $error("locked status write accepted");
	stat_change_a: assert property ($changed(r.stat[7:2]) |-> $past(r.wr_pend))
		else $error("status changed without write");
	quad_pins_a: assert property (!o_io_oe_n[2] || !o_io_oe_n[3] |-> r.stat.quad_io_enable)
		else $error("upper lines driven without quad");
	launch_fall_a: assert property ($changed(o_io_out) |-> $past(fall))
		else $error("output changed off falling edge");
	hold_float_a: assert property (hold && !r.s2.cs_n |=> o_io_oe_n[1])
		else $error("output driven during pause");
	sector_base_a: assert property ($changed(r.ers_addr) |->
		r.ers_addr[11:0] == 12'h000 && r.ers_addr <= dens_top(r.dens))
		else $error("erase base off sector grid");
	blk64_gate_a: assert property ($rose(r.stat.busy) && !r.wr_pend &&
		r.cmd == `SFM_CMD_BE64 |-> r.dens >= `SFM_DENS_BLK64_MIN)
		else $error("64 KB block on small density");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");

	busy_seen_c: cover property ($rose(r.stat.busy));
	quad_out_c: cover property ($fell(o_io_oe_n[3]));
	refuse_c: cover property ($rose(r.ists[`SFM_EV_REFUSE]));
	irq_c: cover property ($rose(o_irq));
endmodule // sfm_top
